// >>> common/stf_pkg.sv
// Constants and types for the serial audio input formatter of the transmitter.
// Assumes a single 20 MHz system clock; all pin inputs are asynchronous.
package stf_pkg;

  // ****************************************
  // Framing formats and word widths
  // ****************************************
  typedef enum logic [1:0] {
    STF_FMT_LEFT_JUST,
    STF_FMT_I2S,
    STF_FMT_RIGHT_JUST
  } stf_fmt_t;

  localparam stf_fmt_t STF_FMT_RESET = STF_FMT_I2S;

  localparam logic [1:0] STF_WID_16 = 2'h0;
  localparam logic [1:0] STF_WID_18 = 2'h1;
  localparam logic [1:0] STF_WID_20 = 2'h2;
  localparam logic [1:0] STF_WID_24 = 2'h3;

  localparam int STF_MAX_BITS = 24;
  localparam int STF_CNT_W = 6;
  localparam logic [STF_CNT_W-1:0] STF_CNT_ZERO = 6'h00;
  localparam logic [STF_CNT_W-1:0] STF_CNT_ONE = 6'h01;
  localparam logic [STF_CNT_W-1:0] STF_CNT_MAX = 6'h3f;
  localparam logic [STF_CNT_W-1:0] STF_CNT_TWO = 6'h02;

  // Word widths in bits, and bit-clock periods in one channel slot
  localparam logic [STF_CNT_W-1:0] STF_BITS_16 = 6'h10;
  localparam logic [STF_CNT_W-1:0] STF_BITS_18 = 6'h12;
  localparam logic [STF_CNT_W-1:0] STF_BITS_20 = 6'h14;
  localparam logic [STF_CNT_W-1:0] STF_BITS_24 = 6'h18;
  localparam logic [STF_CNT_W-1:0] STF_SLOT_BITS = 6'h20;

  // Right-justified lead-in, in bit-clock periods, per word width
  localparam logic [STF_CNT_W-1:0] STF_RJ_DLY_20 = 6'h0c;
  localparam logic [STF_CNT_W-1:0] STF_RJ_DLY_16 = 6'h10;

  // ****************************************
  // Oversampling divider ratios
  // ****************************************
  localparam logic [8:0] STF_OVS_256 = 9'h100;
  localparam logic [8:0] STF_OVS_384 = 9'h180;
  localparam int STF_BIPHASE_PER_FRAME = 128;

endpackage

// >>> rtl/stf_formatter.sv
// Serial audio input formatter: deserialises left and right words and divides
// the oversampling clock into the biphase enable.
// Assumes bit clock, frame clock, data and oversampling clock are asynchronous
// pins, each far slower than the 20 MHz system clock (at least 4x).
`timescale 1ns/1ns
module stf_formatter
  import stf_pkg::*;
#(
  parameter int WIDTH = STF_MAX_BITS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Configuration
  input wire stf_fmt_t i_fmt,
  input wire logic [1:0] i_word_width,
  input wire logic i_ovs_384,
  // Serial audio pins
  input wire logic i_bit_clk,
  input wire logic i_frame_sync,
  input wire logic i_serial_audio_in,
  input wire logic i_oversampling_clock,
  // Sample pair to the biphase encoder
  output logic o_pair_valid,
  output logic [WIDTH-1:0] o_left,
  output logic [WIDTH-1:0] o_right,
  // Biphase clock enable
  output logic o_biphase_en
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [2:0] bck_sync;
    logic [2:0] fs_sync;
    logic [1:0] sd_sync;
    logic [2:0] ovs_sync;
    logic fs_last;
    logic [STF_CNT_W-1:0] bit_cnt;
    logic [WIDTH-1:0] shift;
    logic [STF_CNT_W-1:0] got;
    logic chan_right;
    logic wr;
    logic wr_right;
    logic [WIDTH-1:0] wr_data;
    logic rd;
    logic pair_valid;
    logic [8:0] div_cnt;
    logic biphase_en;
  } stf_state_t;

  stf_state_t st_reg;
  stf_state_t st_next;
  logic [WIDTH-1:0] rd_left;
  logic [WIDTH-1:0] rd_right;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [STF_CNT_W-1:0] width_bits(input logic [1:0] sel);
    logic [STF_CNT_W-1:0] n;
    n = STF_BITS_24;
    if (sel == STF_WID_16) begin
      n = STF_BITS_16;
    end else if (sel == STF_WID_18) begin
      n = STF_BITS_18;
    end else if (sel == STF_WID_20) begin
      n = STF_BITS_20;
    end
    return n;
  endfunction

  // Bit-clock index at which the MSB arrives for the given format
  function automatic logic [STF_CNT_W-1:0] msb_slot(input stf_fmt_t f,
                                                     input logic [1:0] sel);
    logic [STF_CNT_W-1:0] s;
    s = STF_CNT_ZERO;
    case (f)
      STF_FMT_I2S: s = STF_CNT_ONE;
      STF_FMT_RIGHT_JUST: begin
        if (sel == STF_WID_16) begin
          s = STF_RJ_DLY_16;
        end else if (sel == STF_WID_20) begin
          s = STF_RJ_DLY_20;
        end else begin
          // Lead-in so that the LSB ends on the next frame edge at 32 bits per slot
          s = STF_SLOT_BITS - width_bits(sel);
        end
      end
      default: s = STF_CNT_ZERO;
    endcase
    return s;
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic bck_rise;
    logic ovs_rise;
    logic fs_now;
    logic right_now;
    logic [STF_CNT_W-1:0] wb;
    logic [8:0] ratio;
    stf_fmt_t fmt;
    bck_rise = st_reg.bck_sync[1] && !st_reg.bck_sync[2];
    ovs_rise = st_reg.ovs_sync[1] && !st_reg.ovs_sync[2];
    fs_now = st_reg.fs_sync[1];
    wb = width_bits(i_word_width);
    // Codes outside the three formats fall back to the reset default
    fmt = STF_FMT_RESET;
    if (i_fmt == STF_FMT_LEFT_JUST || i_fmt == STF_FMT_RIGHT_JUST) begin
      fmt = i_fmt;
    end
    // I2S marks right with a high frame clock, the others with a low one
    right_now = (fmt == STF_FMT_I2S) ? fs_now : !fs_now;
    ratio = i_ovs_384 ? STF_OVS_384 : STF_OVS_256;
    st_next = st_reg;
    st_next.wr = 1'b0;
    st_next.rd = 1'b0;
    st_next.pair_valid = st_reg.rd;
    st_next.biphase_en = 1'b0;
    st_next.bck_sync = {st_reg.bck_sync[1:0], i_bit_clk};
    st_next.fs_sync = {st_reg.fs_sync[1:0], i_frame_sync};
    st_next.sd_sync = {st_reg.sd_sync[0], i_serial_audio_in};
    st_next.ovs_sync = {st_reg.ovs_sync[1:0], i_oversampling_clock};
    // Sample on bit clock rising edge only
    if (bck_rise) begin
      st_next.fs_last = fs_now;
      if (fs_now != st_reg.fs_last) begin
        st_next.bit_cnt = STF_CNT_ONE;
        st_next.chan_right = right_now;
        st_next.got = STF_CNT_ZERO;
        st_next.shift = '0;
        if (msb_slot(fmt, i_word_width) == STF_CNT_ZERO) begin
          st_next.shift = {{(WIDTH-1){1'b0}}, st_reg.sd_sync[1]};
          st_next.got = STF_CNT_ONE;
        end
      end else begin
        if (st_reg.bit_cnt != STF_CNT_MAX) begin
          st_next.bit_cnt = st_reg.bit_cnt + STF_CNT_ONE;
        end
        if (st_reg.bit_cnt >= msb_slot(fmt, i_word_width) && st_reg.got < wb) begin
          st_next.shift = {st_reg.shift[WIDTH-2:0], st_reg.sd_sync[1]};
          st_next.got = st_reg.got + STF_CNT_ONE;
        end
      end
      // Word complete: store it, right-aligned shift made MSB-justified
      if (st_next.got == wb && st_reg.got != wb) begin
        st_next.wr = 1'b1;
        st_next.wr_right = st_next.chan_right;
        st_next.wr_data = st_next.shift << (STF_MAX_BITS - int'(wb));
        st_next.rd = st_next.chan_right;
      end
    end
    // Oversampling divider: one biphase enable per ratio/128 oversampling edges
    if (ovs_rise) begin
      if (st_reg.div_cnt >= 9'(int'(ratio) / STF_BIPHASE_PER_FRAME - 1)) begin
        st_next.div_cnt = 9'h000;
        st_next.biphase_en = 1'b1;
      end else begin
        st_next.div_cnt = st_reg.div_cnt + 9'h001;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************
  // Sample store and outputs
  // ****************************************
  stf_sample_store #(.WIDTH(WIDTH)) u_store (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_wr(st_reg.wr),
    .i_wr_right(st_reg.wr_right),
    .i_wr_data(st_reg.wr_data),
    .i_rd(st_reg.rd),
    .o_rd_left(rd_left),
    .o_rd_right(rd_right)
  );

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_pair_valid <= 1'b0;
      o_left <= '0;
      o_right <= '0;
      o_biphase_en <= 1'b0;
    end else begin
      o_pair_valid <= st_reg.pair_valid;
      o_left <= rd_left;
      o_right <= rd_right;
      o_biphase_en <= st_reg.biphase_en;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  a_pair_after_right: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_reg.rd |-> st_reg.wr && st_reg.wr_right ##2 o_pair_valid)
    else $error("pair not delivered two cycles after right word");

  a_pair_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_pair_valid |=> !o_pair_valid)
    else $error("pair valid longer than one cycle");

  a_word_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(st_reg.got) |-> st_reg.got <= width_bits(i_word_width))
    else $error("more bits taken than word width");

  a_sample_rise: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $changed(st_reg.got) && st_reg.got != STF_CNT_ZERO
      |-> $past(st_reg.bck_sync[1]) && !$past(st_reg.bck_sync[2]))
    else $error("bit taken without bit clock rise");

  a_shift_late: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fmt == STF_FMT_I2S && st_reg.bit_cnt == STF_CNT_ONE && $changed(st_reg.bit_cnt))
      |-> st_reg.got == STF_CNT_ZERO)
    else $error("I2S bit taken on edge slot");

  a_lj_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fmt == STF_FMT_LEFT_JUST && $changed(st_reg.bit_cnt) && st_reg.bit_cnt == STF_CNT_ONE)
      |-> st_reg.got == STF_CNT_ONE)
    else $error("left-justified MSB not taken at edge");

  a_chan_pol: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(st_reg.fs_last) && $stable(i_fmt) && i_fmt == STF_FMT_I2S)
      |-> st_reg.chan_right == st_reg.fs_last)
    else $error("I2S channel polarity wrong");

  a_div_bound: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_reg.div_cnt < 9'(int'(STF_OVS_384) / STF_BIPHASE_PER_FRAME))
    else $error("divider count out of range");

  a_biphase_pulse: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st_reg.biphase_en |-> $past(st_reg.ovs_sync[1]) && !$past(st_reg.ovs_sync[2]))
    else $error("biphase enable without oversampling edge");

  a_biphase_single: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_biphase_en |=> !o_biphase_en)
    else $error("biphase enable longer than one cycle");

  a_msb_first: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(st_reg.got) && st_reg.got != STF_CNT_ZERO)
      |-> st_reg.shift[0] == $past(st_reg.sd_sync[1]))
    else $error("captured bit differs from sampled data");

  a_pair_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(o_left) || $changed(o_right)) |-> o_pair_valid)
    else $error("sample outputs changed without pair valid");

  a_left_no_pair: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_reg.wr && !st_reg.wr_right) |-> !st_reg.rd)
    else $error("left word alone started a pair");

  a_lj_pol: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(st_reg.fs_last) && $stable(i_fmt) && i_fmt == STF_FMT_LEFT_JUST)
      |-> st_reg.chan_right != st_reg.fs_last)
    else $error("left-justified channel polarity wrong");

  a_rj_pol: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    ($changed(st_reg.fs_last) && $stable(i_fmt) && i_fmt == STF_FMT_RIGHT_JUST)
      |-> st_reg.chan_right != st_reg.fs_last)
    else $error("right-justified channel polarity wrong");

  a_i2s_lead: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fmt == STF_FMT_I2S && $stable(i_fmt) && $changed(st_reg.got) && st_reg.got == STF_CNT_ONE)
      |-> st_reg.bit_cnt == STF_CNT_TWO)
    else $error("I2S MSB not taken one period after frame edge");

  a_rj_lead20: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fmt == STF_FMT_RIGHT_JUST && i_word_width == STF_WID_20 && $stable(i_fmt)
      && $changed(st_reg.got) && st_reg.got == STF_CNT_ONE)
      |-> st_reg.bit_cnt == STF_RJ_DLY_20 + STF_CNT_ONE)
    else $error("right-justified 20-bit MSB slot wrong");

  a_rj_lead16: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_fmt == STF_FMT_RIGHT_JUST && i_word_width == STF_WID_16 && $stable(i_fmt)
      && $changed(st_reg.got) && st_reg.got == STF_CNT_ONE)
      |-> st_reg.bit_cnt == STF_RJ_DLY_16 + STF_CNT_ONE)
    else $error("right-justified 16-bit MSB slot wrong");

  a_lsb_frame: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_reg.wr && i_fmt == STF_FMT_RIGHT_JUST && $stable(i_fmt))
      |-> st_reg.bit_cnt == STF_SLOT_BITS)
    else $error("right-justified LSB not at end of slot");

endmodule

// >>> rtl/stf_sample_store.sv
// Holds the finished left and right sample pair with a registered read port.
// Assumes writes and reads come from the same clock domain.
`timescale 1ns/1ns
module stf_sample_store
  import stf_pkg::*;
#(
  parameter int WIDTH = STF_MAX_BITS
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Write side
  input wire logic i_wr,
  input wire logic i_wr_right,
  input wire logic [WIDTH-1:0] i_wr_data,
  // Read side
  input wire logic i_rd,
  output logic [WIDTH-1:0] o_rd_left,
  output logic [WIDTH-1:0] o_rd_right
);

  logic [WIDTH-1:0] mem_reg [2];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mem_reg[0] <= '0;
      mem_reg[1] <= '0;
      o_rd_left <= '0;
      o_rd_right <= '0;
    end else begin
      if (i_wr) begin
        mem_reg[i_wr_right] <= i_wr_data;
      end
      if (i_rd) begin
        o_rd_left <= mem_reg[0];
        o_rd_right <= i_wr && i_wr_right ? i_wr_data : mem_reg[1];
      end
    end
  end

endmodule

// >>> tb/stf_audio_src.sv
// Behavioural serial audio source and free-running oversampling clock.
// Assumes the bench calls send_half from its own sequence.
`timescale 1ns/1ns
module stf_audio_src (
  // Clock
  input wire logic i_clk,
  // Serial audio pins
  output logic o_bit_clk,
  output logic o_frame_sync,
  output logic o_serial_audio_in,
  output logic o_ovs_clk
);
  initial begin
    o_bit_clk = 1'b0;
    o_frame_sync = 1'b0;
    o_serial_audio_in = 1'b0;
    o_ovs_clk = 1'b0;
    forever begin
      repeat (4) @(posedge i_clk);
      o_ovs_clk <= ~o_ovs_clk;
    end
  end

  // One channel slot run; level and data change while the bit clock is low
  task automatic send_half(input logic lvl, input int m, input int w,
      input logic [23:0] word, input int n);
    for (int s = 0; s < n; s++) begin
      @(posedge i_clk);
      o_bit_clk <= 1'b0;
      o_frame_sync <= lvl;
      o_serial_audio_in <= (s >= m && s < m + w) ? word[23 - (s - m)] : s[0];
      repeat (4) @(posedge i_clk);
      o_bit_clk <= 1'b1;
      repeat (3) @(posedge i_clk);
    end
  endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench for the serial audio input formatter.
// Assumes the design package and the audio source model are compiled first.
`timescale 1ns/1ns
module tb;
  import stf_pkg::*;
  typedef struct {stf_fmt_t fmt; logic [1:0] wc; logic [23:0] l; logic [23:0] r;} stf_row_t;
  logic i_clk;
  logic i_sys_rst;
  logic i_ovs_384;
  stf_fmt_t i_fmt;
  logic [1:0] i_word_width;
  logic bclk, fsync, serial_audio_in, ovs, o_pair_valid, o_biphase_en;
  logic [23:0] o_left, o_right, cap_l, cap_r;
  int n_errors = 0, n_compared = 0, n_pairs = 0, n_bi = 0, base, g;
  // Each row: sent word, equal to the MSB-justified output expected
  stf_row_t rows [7] = '{
    '{STF_FMT_LEFT_JUST, STF_WID_16, 24'h8f1200, 24'h3ca500},
    '{STF_FMT_LEFT_JUST, STF_WID_24, 24'hc35a96, 24'h0f0f0f},
    '{STF_FMT_I2S, STF_WID_18, 24'had2c40, 24'h5e1780},
    '{STF_FMT_I2S, STF_WID_16, 24'h7e8100, 24'h81ff00},
    '{STF_FMT_RIGHT_JUST, STF_WID_20, 24'h9abcd0, 24'h135790},
    '{STF_FMT_RIGHT_JUST, STF_WID_16, 24'hbeef00, 24'h0a0b00},
    '{STF_FMT_RIGHT_JUST, STF_WID_24, 24'h123456, 24'hfedcba}};

  stf_formatter u_dut (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_fmt(i_fmt), .i_word_width(i_word_width),
    .i_ovs_384(i_ovs_384), .i_bit_clk(bclk), .i_frame_sync(fsync), .i_serial_audio_in(serial_audio_in),
    .i_oversampling_clock(ovs), .o_pair_valid(o_pair_valid), .o_left(o_left),
    .o_right(o_right), .o_biphase_en(o_biphase_en));
  stf_audio_src u_src (
    .i_clk(i_clk), .o_bit_clk(bclk), .o_frame_sync(fsync), .o_serial_audio_in(serial_audio_in), .o_ovs_clk(ovs));

  // ****************************************
  // Monitors and helpers
  // ****************************************
  always @(posedge i_clk) begin
    if (o_pair_valid === 1'b1) begin
      n_pairs++;
      cap_l = o_left;
      cap_r = o_right;
    end
    if (o_biphase_en === 1'b1) n_bi++;
  end

  task automatic report_and_stop();
    $display("Errors %0d, comparisons %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [23:0] e, input logic [23:0] s);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic run_row(input stf_row_t rw);
    int w, m;
    logic lft;
    w = (rw.wc == STF_WID_16) ? 16 : (rw.wc == STF_WID_18) ? 18 :
        (rw.wc == STF_WID_20) ? 20 : 24;
    m = (rw.fmt == STF_FMT_LEFT_JUST) ? 0 : (rw.fmt == STF_FMT_I2S) ? 1 : 32 - w;
    lft = (rw.fmt != STF_FMT_I2S);
    @(posedge i_clk);
    i_fmt <= rw.fmt;
    i_word_width <= rw.wc;
    if (fsync === lft) u_src.send_half(!lft, 0, 16, 24'h0, 2);
    base = n_pairs;
    u_src.send_half(lft, m, w, rw.l, 32);
    check("pairs after left", 24'(base), 24'(n_pairs));
    u_src.send_half(!lft, m, w, rw.r, 32);
    for (int k = 0; k < 60 && n_pairs == base; k++) @(posedge i_clk);
    if (n_pairs == base) begin
      n_errors++;
      $display("ERROR pair wait expected 1 seen 0");
      report_and_stop();
    end
    check("pair count", 24'(base + 1), 24'(n_pairs));
    check("left", rw.l, cap_l);
    check("right", rw.r, cap_r);
  endtask

  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  initial begin
    i_sys_rst = 1'b1;
    i_fmt = STF_FMT_RESET;
    i_word_width = STF_WID_16;
    i_ovs_384 = 1'b0;
    repeat (12) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    foreach (rows[i]) run_row(rows[i]);
    fork
      u_src.send_half(1'b1, 0, 24, 24'hffffff, 32);
      begin
        repeat (100) @(posedge i_clk);
        i_sys_rst <= 1'b1;
        repeat (3) @(posedge i_clk);
        check("valid in reset", 24'h0, {23'h0, o_pair_valid});
        check("left in reset", 24'h0, o_left);
        check("right in reset", 24'h0, o_right);
        check("biphase in reset", 24'h0, {23'h0, o_biphase_en});
        i_sys_rst <= 1'b0;
      end
    join
    run_row('{STF_FMT_RESET, STF_WID_24, 24'h5a5a5a, 24'ha5c3e1});
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clk);
      i_ovs_384 <= k[0];
      repeat (16) @(posedge i_clk);
      base = n_bi;
      repeat (384) @(posedge i_clk);
      g = n_bi - base;
      check("biphase rate", 24'h1, {23'h0, g >= (k ? 15 : 23) && g <= (k ? 17 : 25)});
    end
    report_and_stop();
  end
endmodule
